// >>> drive_status_pkg.sv
// constants, codes and register map of the drive status output logic
package drive_status_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_DO_SELECT    = 8'h00;
  localparam logic [7:0] OFS_PROT_MASK    = 8'h04;
  localparam logic [7:0] OFS_REACH_FREQ   = 8'h08;
  localparam logic [7:0] OFS_SKIP_CENTER  = 8'h0C;
  localparam logic [7:0] OFS_SKIP_BAND    = 8'h10;
  localparam logic [7:0] OFS_DECEL_OV     = 8'h14;
  localparam logic [7:0] OFS_ACCEL_STALL  = 8'h18;
  localparam logic [7:0] OFS_RUN_STALL    = 8'h1C;
  localparam logic [7:0] OFS_THERMAL_LVL  = 8'h20;
  localparam logic [7:0] OFS_RATED_CUR    = 8'h24;
  localparam logic [7:0] OFS_STATUS       = 8'h28;
  localparam logic [7:0] OFS_STEADY_FREQ  = 8'h2C;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [3:0]  RST_DO_SELECT   = 4'hA;
  localparam logic [4:0]  RST_PROT_MASK   = 5'h07;
  localparam logic [15:0] RST_REACH_FREQ  = 16'h1770;
  localparam logic [15:0] RST_SKIP_CENTER = 16'h0000;
  localparam logic [15:0] RST_SKIP_BAND   = 16'h0000;
  localparam logic [15:0] RST_DECEL_OV    = 16'h0175;
  localparam logic [7:0]  RST_ACCEL_STALL = 8'hAA;
  localparam logic [7:0]  RST_RUN_STALL   = 8'hA0;
  localparam logic [7:0]  RST_THERMAL_LVL = 8'h96;
  localparam logic [15:0] RST_RATED_CUR   = 16'h0190;

  // ************************************************************
  // limits and scaling
  // ************************************************************
  localparam logic [15:0] REACH_FREQ_MAX  = 16'h7530;
  localparam logic [15:0] SKIP_CENTER_MAX = 16'h7530;
  localparam logic [15:0] SKIP_BAND_MAX   = 16'h03E8;
  localparam logic [16:0] REACH_HYST      = 17'h00032;
  localparam logic [7:0]  LEVEL_SCALE     = 8'h64;

  // ************************************************************
  // protection mask bit positions
  // ************************************************************
  localparam int MASK_DECEL_OV   = 0;
  localparam int MASK_ACCEL_CUR  = 1;
  localparam int MASK_RUN_CUR    = 2;
  localparam int MASK_THERMAL    = 3;
  localparam int MASK_AVR        = 4;

  // ************************************************************
  // output function codes
  // ************************************************************
  typedef enum logic [3:0] {
    FN_DISABLED = 4'h0,
    FN_FAULT    = 4'h1,
    FN_RUNNING  = 4'h2,
    FN_ZERO_SPD = 4'h3,
    FN_FORWARD  = 4'h4,
    FN_REVERSE  = 4'h5,
    FN_ACCEL    = 4'h6,
    FN_DECEL    = 4'h7,
    FN_STAGE    = 4'h8,
    FN_OVERLOAD = 4'h9,
    FN_REACH    = 4'hA
  } do_func_t;

  typedef enum logic [1:0] {
    REACH_OFF = 2'b01,
    REACH_ON  = 2'b10
  } reach_state_t;

endpackage

// >>> protection_if.sv
// carrier between the status logic and the protection gate
`timescale 1ns/1ps
interface protection_if;
  logic [4:0]  mask;
  logic [15:0] dcBusVolt;
  logic [15:0] decelOvLevel;
  logic [15:0] outCurrent;
  logic [15:0] ratedCurrent;
  logic [7:0]  accelLevel;
  logic [7:0]  runLevel;
  logic [7:0]  thermalLevel;
  logic        accelerating;
  logic        decelerating;
  logic        steady;
  logic        decelHold;
  logic        accelHold;
  logic        runHold;
  logic        overload;
  logic        thermalRun;
  logic        avrEnable;

  modport owner (output mask, dcBusVolt, decelOvLevel, outCurrent, ratedCurrent, accelLevel, runLevel,
                 thermalLevel, accelerating, decelerating, steady,
                 input decelHold, accelHold, runHold, overload, thermalRun, avrEnable);
  modport guard (input mask, dcBusVolt, decelOvLevel, outCurrent, ratedCurrent, accelLevel, runLevel,
                 thermalLevel, accelerating, decelerating, steady,
                 output decelHold, accelHold, runHold, overload, thermalRun, avrEnable);
endinterface

// >>> protection_gate.sv
// stall, thermal and voltage regulation enables
`timescale 1ns/1ps
module protection_gate
  import drive_status_pkg::*;
(
  protection_if.guard pif
);

  // ************************************************************
  // scaled current limits
  // ************************************************************
  // levels are hundredths of rated current, so scale current by 100 instead of dividing
  logic [23:0] curScaled;
  logic [23:0] accelLimit;
  logic [23:0] runLimit;
  logic [23:0] thermalLimit;

  always_comb begin
    curScaled    = pif.outCurrent * LEVEL_SCALE;
    accelLimit   = pif.ratedCurrent * pif.accelLevel;
    runLimit     = pif.ratedCurrent * pif.runLevel;
    thermalLimit = pif.ratedCurrent * pif.thermalLevel;
  end

  // ************************************************************
  // protections gated by the mask bits, and the ungated overload flag
  // ************************************************************
  always_comb begin
    pif.decelHold  = pif.mask[MASK_DECEL_OV] && pif.decelerating && (pif.dcBusVolt > pif.decelOvLevel);
    pif.accelHold  = pif.mask[MASK_ACCEL_CUR] && pif.accelerating && (curScaled > accelLimit);
    pif.runHold    = pif.mask[MASK_RUN_CUR] && pif.steady && (curScaled > runLimit);
    pif.overload   = curScaled > thermalLimit;
    pif.thermalRun = pif.mask[MASK_THERMAL] && pif.overload;
    pif.avrEnable  = pif.mask[MASK_AVR];
  end

endmodule

// >>> drive_status_output_logic.sv
// digital status output, skip band and protection enables of the drive
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps

// Summary of operation
// - selector codes 0..10, code 0 inactive
// - code 1: output on at fault
// - code 2: on in standby or run
// - code 3: on stopped or zero frequency
// - code 4: forward command and frequency above zero
// - code 5: reverse command and frequency above zero
// - code 6: on while ramping up
// - code 7: on while ramping down
// - code 8: frequency equals active stage speed
// - code 9: on at overload, keeps running
// - overload is current above rated times level
// - code 10: on at frequency reaching setpoint
// - off only below setpoint minus 0.5 Hz
// - steady frequency never held inside skip band
// - zero skip band disables skipping
// - mask bit0 enables decel voltage stall
// - mask bit1 enables accel current stall
// - mask bit2 enables run current stall
// - mask bit3 enables thermal overload relay
// - mask bit4 enables output voltage regulation
// - hold decel while bus above threshold
// - hold accel while current above level
module drive_status_output_logic
  import drive_status_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        faultDetected,
  input  wire logic        driveActive,
  input  wire logic        forwardRunCommand,
  input  wire logic        reverseRunCommand,
  input  wire logic        rampUp,
  input  wire logic        rampDown,
  input  wire logic        analogSpeedCommand,
  input  wire logic [15:0] outFreq,
  input  wire logic [15:0] stageFreq,
  input  wire logic [15:0] targetFreq,
  input  wire logic [15:0] outCurrent,
  input  wire logic [15:0] dcBusVolt,
  output logic             digitalOut,
  output logic      [15:0] steadyTargetFreq,
  output logic             decelHold,
  output logic             accelHold,
  output logic             runHold,
  output logic             thermalTimerRun,
  output logic             avrEnable
);

  // ************************************************************
  // register file state
  // ************************************************************
  logic [3:0]   doSelect_reg;
  logic [3:0]   doSelect_next;
  logic [4:0]   protMask_reg;
  logic [4:0]   protMask_next;
  logic [15:0]  reachFreq_reg;
  logic [15:0]  reachFreq_next;
  logic [15:0]  skipCenter_reg;
  logic [15:0]  skipCenter_next;
  logic [15:0]  skipBand_reg;
  logic [15:0]  skipBand_next;
  logic [15:0]  decelOv_reg;
  logic [15:0]  decelOv_next;
  logic [7:0]   accelStall_reg;
  logic [7:0]   accelStall_next;
  logic [7:0]   runStall_reg;
  logic [7:0]   runStall_next;
  logic [7:0]   thermalLvl_reg;
  logic [7:0]   thermalLvl_next;
  logic [15:0]  ratedCur_reg;
  logic [15:0]  ratedCur_next;
  logic [31:0]  rdata_reg;
  logic [31:0]  rdata_next;

  // ************************************************************
  // status state
  // ************************************************************
  reach_state_t reachState_reg;
  reach_state_t reachState_next;
  logic         digitalOut_reg;
  logic         digitalOut_next;
  logic [15:0]  steady_reg;
  logic [15:0]  steady_next;
  logic         decelHold_reg;
  logic         accelHold_reg;
  logic         runHold_reg;
  logic         thermal_reg;
  logic         avr_reg;

  // ************************************************************
  // protection gate
  // ************************************************************
  protection_if pif ();

  always_comb begin
    pif.mask         = protMask_reg;
    pif.dcBusVolt    = dcBusVolt;
    pif.decelOvLevel = decelOv_reg;
    pif.outCurrent   = outCurrent;
    pif.ratedCurrent = ratedCur_reg;
    pif.accelLevel   = accelStall_reg;
    pif.runLevel     = runStall_reg;
    pif.thermalLevel = thermalLvl_reg;
    pif.accelerating = rampUp;
    pif.decelerating = rampDown;
    pif.steady       = driveActive && !rampUp && !rampDown;
  end

  protection_gate u_gate (
    .pif (pif.guard)
  );

  // ************************************************************
  // register write decode
  // ************************************************************
  // out-of-range setpoints clamp to the top of their range rather than wrap
  always_comb begin
    doSelect_next   = doSelect_reg;
    protMask_next   = protMask_reg;
    reachFreq_next  = reachFreq_reg;
    skipCenter_next = skipCenter_reg;
    skipBand_next   = skipBand_reg;
    decelOv_next    = decelOv_reg;
    accelStall_next = accelStall_reg;
    runStall_next   = runStall_reg;
    thermalLvl_next = thermalLvl_reg;
    ratedCur_next   = ratedCur_reg;
    if (regWrite) begin
      if (regAddr == OFS_DO_SELECT) begin
        doSelect_next = regWdata[3:0];
      end else if (regAddr == OFS_PROT_MASK) begin
        protMask_next = regWdata[4:0];
      end else if (regAddr == OFS_REACH_FREQ) begin
        reachFreq_next = (regWdata[15:0] > REACH_FREQ_MAX) ? REACH_FREQ_MAX : regWdata[15:0];
      end else if (regAddr == OFS_SKIP_CENTER) begin
        skipCenter_next = (regWdata[15:0] > SKIP_CENTER_MAX) ? SKIP_CENTER_MAX : regWdata[15:0];
      end else if (regAddr == OFS_SKIP_BAND) begin
        skipBand_next = (regWdata[15:0] > SKIP_BAND_MAX) ? SKIP_BAND_MAX : regWdata[15:0];
      end else if (regAddr == OFS_DECEL_OV) begin
        decelOv_next = regWdata[15:0];
      end else if (regAddr == OFS_ACCEL_STALL) begin
        accelStall_next = regWdata[7:0];
      end else if (regAddr == OFS_RUN_STALL) begin
        runStall_next = regWdata[7:0];
      end else if (regAddr == OFS_THERMAL_LVL) begin
        thermalLvl_next = regWdata[7:0];
      end else if (regAddr == OFS_RATED_CUR) begin
        ratedCur_next = regWdata[15:0];
      end
    end
  end

  // ************************************************************
  // register read decode
  // ************************************************************
  // unmapped reads return zero and the data stand for one cycle only
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (regRead) begin
      if (regAddr == OFS_DO_SELECT) begin
        rdata_next = {28'h000_0000, doSelect_reg};
      end else if (regAddr == OFS_PROT_MASK) begin
        rdata_next = {27'h000_0000, protMask_reg};
      end else if (regAddr == OFS_REACH_FREQ) begin
        rdata_next = {16'h0000, reachFreq_reg};
      end else if (regAddr == OFS_SKIP_CENTER) begin
        rdata_next = {16'h0000, skipCenter_reg};
      end else if (regAddr == OFS_SKIP_BAND) begin
        rdata_next = {16'h0000, skipBand_reg};
      end else if (regAddr == OFS_DECEL_OV) begin
        rdata_next = {16'h0000, decelOv_reg};
      end else if (regAddr == OFS_ACCEL_STALL) begin
        rdata_next = {24'h00_0000, accelStall_reg};
      end else if (regAddr == OFS_RUN_STALL) begin
        rdata_next = {24'h00_0000, runStall_reg};
      end else if (regAddr == OFS_THERMAL_LVL) begin
        rdata_next = {24'h00_0000, thermalLvl_reg};
      end else if (regAddr == OFS_RATED_CUR) begin
        rdata_next = {16'h0000, ratedCur_reg};
      end else if (regAddr == OFS_STATUS) begin
        rdata_next = {24'h00_0000, avr_reg, thermal_reg, runHold_reg, accelHold_reg,
                      decelHold_reg, pif.overload, reachState_reg == REACH_ON, digitalOut_reg};
      end else if (regAddr == OFS_STEADY_FREQ) begin
        rdata_next = {16'h0000, steady_reg};
      end
    end
  end

  // ************************************************************
  // reach frequency hysteresis
  // ************************************************************
  always_comb begin
    reachState_next = reachState_reg;
    case (reachState_reg)
      REACH_OFF: begin
        if (outFreq >= reachFreq_reg) begin
          reachState_next = REACH_ON;
        end
      end
      REACH_ON: begin
        // release below hysteresis
        // a setpoint under 0.5 Hz never releases, since frequency cannot go negative
        if (({1'b0, outFreq} + REACH_HYST) < {1'b0, reachFreq_reg}) begin
          reachState_next = REACH_OFF;
        end
      end
      default: begin
        reachState_next = REACH_OFF;
      end
    endcase
  end

  // ************************************************************
  // output function select
  // ************************************************************
  always_comb begin
    digitalOut_next = 1'b0;
    case (doSelect_reg)
      FN_DISABLED: digitalOut_next = 1'b0;
      FN_FAULT:    digitalOut_next = faultDetected;
      FN_RUNNING:  digitalOut_next = driveActive;
      FN_ZERO_SPD: digitalOut_next = !driveActive || (outFreq == 16'h0000);
      FN_FORWARD:  digitalOut_next = forwardRunCommand && (outFreq != 16'h0000);
      FN_REVERSE:  digitalOut_next = reverseRunCommand && (outFreq != 16'h0000);
      FN_ACCEL:    digitalOut_next = rampUp;
      FN_DECEL:    digitalOut_next = rampDown;
      // stage speed match
      // analog commands never match; their value jitters around the target
      FN_STAGE:    digitalOut_next = !analogSpeedCommand && (outFreq == stageFreq);
      FN_OVERLOAD: digitalOut_next = pif.overload;
      FN_REACH:    digitalOut_next = (reachState_next == REACH_ON);
      default:     digitalOut_next = 1'b0;
    endcase
  end

  // ************************************************************
  // skip band on the steady target
  // ************************************************************
  logic [16:0] bandLow;
  logic [16:0] bandHigh;

  always_comb begin
    bandLow     = (skipCenter_reg > skipBand_reg) ? {1'b0, skipCenter_reg - skipBand_reg} : 17'h00000;
    bandHigh    = {1'b0, skipCenter_reg} + {1'b0, skipBand_reg};
    steady_next = targetFreq;
    if (skipBand_reg != 16'h0000) begin
      // move target out of band
      // ramps still cross the band; only the resting point is moved to its nearer edge
      if (({1'b0, targetFreq} > bandLow) && ({1'b0, targetFreq} < bandHigh)) begin
        if (targetFreq < skipCenter_reg) begin
          steady_next = bandLow[15:0];
        end else begin
          steady_next = (bandHigh[16]) ? 16'hFFFF : bandHigh[15:0];
        end
      end
    end
  end

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      doSelect_reg   <= RST_DO_SELECT;
      protMask_reg   <= RST_PROT_MASK;
      reachFreq_reg  <= RST_REACH_FREQ;
      skipCenter_reg <= RST_SKIP_CENTER;
      skipBand_reg   <= RST_SKIP_BAND;
      decelOv_reg    <= RST_DECEL_OV;
      accelStall_reg <= RST_ACCEL_STALL;
      runStall_reg   <= RST_RUN_STALL;
      thermalLvl_reg <= RST_THERMAL_LVL;
      ratedCur_reg   <= RST_RATED_CUR;
      rdata_reg      <= 32'h0000_0000;
      reachState_reg <= REACH_OFF;
      digitalOut_reg <= 1'b0;
      steady_reg     <= 16'h0000;
      decelHold_reg  <= 1'b0;
      accelHold_reg  <= 1'b0;
      runHold_reg    <= 1'b0;
      thermal_reg    <= 1'b0;
      avr_reg        <= 1'b0;
    end else begin
      doSelect_reg   <= doSelect_next;
      protMask_reg   <= protMask_next;
      reachFreq_reg  <= reachFreq_next;
      skipCenter_reg <= skipCenter_next;
      skipBand_reg   <= skipBand_next;
      decelOv_reg    <= decelOv_next;
      accelStall_reg <= accelStall_next;
      runStall_reg   <= runStall_next;
      thermalLvl_reg <= thermalLvl_next;
      ratedCur_reg   <= ratedCur_next;
      rdata_reg      <= rdata_next;
      reachState_reg <= reachState_next;
      digitalOut_reg <= digitalOut_next;
      steady_reg     <= steady_next;
      decelHold_reg  <= pif.decelHold;
      accelHold_reg  <= pif.accelHold;
      runHold_reg    <= pif.runHold;
      thermal_reg    <= pif.thermalRun;
      avr_reg        <= pif.avrEnable;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    regRdata         = rdata_reg;
    digitalOut       = digitalOut_reg;
    steadyTargetFreq = steady_reg;
    decelHold        = decelHold_reg;
    accelHold        = accelHold_reg;
    runHold          = runHold_reg;
    thermalTimerRun  = thermal_reg;
    avrEnable        = avr_reg;
  end

endmodule

// >>> drive_status_monitor.sv
// assertion checker on the ports of the drive status output logic
`timescale 1ns/1ps
module drive_status_monitor
  import drive_status_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        faultDetected,
  input wire logic        driveActive,
  input wire logic        forwardRunCommand,
  input wire logic [15:0] outFreq,
  input wire logic        rampDown,
  input wire logic [15:0] dcBusVolt,
  input wire logic        digitalOut,
  input wire logic        decelHold,
  input wire logic        thermalTimerRun,
  input wire logic        avrEnable
);
  // ************************************************************
  // shadow of written settings
  // ************************************************************
  // checks wait two quiet cycles after any write, trading reach for safety
  logic [3:0]  selReg, selNext;
  logic [4:0]  maskReg, maskNext;
  logic [15:0] reachReg, reachNext;
  logic [1:0]  ageReg, ageNext;
  logic        settled;
  assign settled = (ageReg == 2'h2);
  always_comb begin
    selNext = selReg;
    maskNext = maskReg;
    reachNext = reachReg;
    ageNext = settled ? ageReg : ageReg + 2'h1;
    if (regWrite) begin
      ageNext = 2'h0;
      if (regAddr == OFS_DO_SELECT) selNext = regWdata[3:0];
      if (regAddr == OFS_PROT_MASK) maskNext = regWdata[4:0];
      if (regAddr == OFS_REACH_FREQ) reachNext = (regWdata[15:0] > REACH_FREQ_MAX) ? REACH_FREQ_MAX : regWdata[15:0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selReg <= RST_DO_SELECT;
      maskReg <= RST_PROT_MASK;
      reachReg <= RST_REACH_FREQ;
      ageReg <= 2'h0;
    end else begin
      selReg <= selNext;
      maskReg <= maskNext;
      reachReg <= reachNext;
      ageReg <= ageNext;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_off_codes: assert property (settled && (selReg == 4'h0 || selReg > 4'hA) |-> !digitalOut)
    else $error("output on while disabled");
  chk_fault_code: assert property (settled && selReg == 4'h1 |-> digitalOut == $past(faultDetected))
    else $error("fault output mismatch");
  chk_zero_speed: assert property (settled && selReg == 4'h3 |->
    digitalOut == (!$past(driveActive) || $past(outFreq) == 16'h0000)) else $error("zero speed mismatch");
  chk_fwd_run: assert property (settled && selReg == 4'h4 |->
    digitalOut == ($past(forwardRunCommand) && $past(outFreq) != 16'h0000)) else $error("forward mismatch");
  chk_reach_set: assert property (settled && selReg == 4'hA && $past(outFreq) >= reachReg |-> digitalOut)
    else $error("reach not set");
  chk_reach_drop: assert property (settled && selReg == 4'hA &&
    {1'b0, $past(outFreq)} + REACH_HYST < {1'b0, reachReg} |-> !digitalOut) else $error("reach not released");
  chk_reach_hold: assert property (settled && selReg == 4'hA && $past(digitalOut) &&
    {1'b0, $past(outFreq)} + REACH_HYST >= {1'b0, reachReg} |-> digitalOut) else $error("reach dropped early");
  chk_decel_stall: assert property (settled |-> decelHold ==
    (maskReg[MASK_DECEL_OV] && $past(rampDown) && $past(dcBusVolt) > RST_DECEL_OV)) else $error("decel hold");
  chk_avr_mask: assert property (settled |-> avrEnable == maskReg[MASK_AVR])
    else $error("voltage regulation enable mismatch");
  chk_thermal_mask: assert property (settled && !maskReg[MASK_THERMAL] |-> !thermalTimerRun)
    else $error("thermal timer while masked");
  cov_reach_on: cover property (selReg == 4'hA && $rose(digitalOut));
  cov_decel: cover property ($rose(decelHold));
  cov_read: cover property ($past(regRead) && regRdata != 32'h0);
endmodule

// >>> contact_load.sv
// load model wired to the status output contact
`timescale 1ns/1ps
module contact_load (
  input  wire logic digitalOut,
  output logic      contactClosed
);
  // contact path only
  // no analog output is read, so that path stays disabled
  assign contactClosed = digitalOut;
endmodule

// >>> tb_top.sv
// self-checking bench of the drive status output logic
`timescale 1ns/1ps
module tb_top;
  import drive_status_pkg::*;
  localparam logic [31:0] RST_TAB [10] = '{32'hA, 32'h7, 32'h1770, 32'h0, 32'h0, 32'h175, 32'hAA, 32'hA0, 32'h96, 32'h190};
  localparam logic [6:0]  PAT_F [3] = '{7'h74, 7'h0A, 7'h29};
  localparam logic [15:0] PAT_Q [3] = '{16'h03E8, 16'h0000, 16'h03E8};
  localparam logic [15:0] PAT_S [3] = '{16'h03E8, 16'h0005, 16'h03E8};
  localparam logic [15:0] PAT_C [3] = '{16'h02BC, 16'h0064, 16'h0258};
  localparam logic [15:0] PAT_E [3] = '{16'h0356, 16'h0088, 16'h0024};
  localparam logic [15:0] REACH_Q [6] = '{16'h0BB8, 16'h0B87, 16'h0B86, 16'h0B85, 16'h0BB7, 16'h0BB8};
  localparam logic [5:0]  REACH_E = 6'h27;
  localparam logic [15:0] SKIP_T [5] = '{16'h137E, 16'h1388, 16'h1324, 16'h13EB, 16'h13EC};
  localparam logic [15:0] SKIP_E [5] = '{16'h1324, 16'h13EC, 16'h1324, 16'h13EC, 16'h13EC};
  logic        clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [6:0]  flags = 7'h00;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [15:0] outFreq = 16'h0, stageFreq = 16'h0, targetFreq = 16'h0, outCurrent = 16'h0, dcBusVolt = 16'h0;
  logic [15:0] steadyTargetFreq;
  logic        digitalOut, decelHold, accelHold, runHold, thermalTimerRun, avrEnable, contactClosed;
  int          errors = 0, comparisons = 0;
  drive_status_output_logic dut_u (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .faultDetected(flags[6]), .driveActive(flags[5]), .forwardRunCommand(flags[4]), .reverseRunCommand(flags[3]),
    .rampUp(flags[2]), .rampDown(flags[1]), .analogSpeedCommand(flags[0]), .outFreq, .stageFreq, .targetFreq,
    .outCurrent, .dcBusVolt, .digitalOut, .steadyTargetFreq, .decelHold, .accelHold, .runHold, .thermalTimerRun,
    .avrEnable);
  contact_load load_u (.digitalOut, .contactClosed);
  initial begin
    forever #25 clk = ~clk;
  end
  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk("regRdata", exp, regRdata);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // flags: fault, active, forward, reverse, ramp up, ramp down, analog
  task automatic drive(input logic [6:0] f, input logic [15:0] fr, st, cur, bus = 16'h0);
    @(posedge clk);
    flags <= f;
    outFreq <= fr;
    stageFreq <= st;
    outCurrent <= cur;
    dcBusVolt <= bus;
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond what the tests need
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    $display("Error watchdog expected done seen hang");
    close_out();
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(i * 4), RST_TAB[i]);
    wr(8'h30, 32'h5A);
    rd(8'h30, 32'h0);
    $display("test reset values done");
    for (int p = 0; p < 3; p++) begin
      drive(PAT_F[p], PAT_Q[p], PAT_S[p], PAT_C[p]);
      for (int c = 0; c < 16; c++) begin
        wr(OFS_DO_SELECT, 32'(c));
        step(3);
        chk("contactClosed", 32'(PAT_E[p][c]), 32'(contactClosed));
      end
    end
    $display("test code table done");
    wr(OFS_DO_SELECT, 32'hA);
    wr(OFS_REACH_FREQ, 32'h0BB8);
    for (int i = 0; i < 6; i++) begin
      drive(7'h20, REACH_Q[i], 16'h0, 16'h0);
      step(1);
      chk("digitalOut", 32'(REACH_E[i]), 32'(digitalOut));
    end
    wr(OFS_REACH_FREQ, 32'hFFFF);
    rd(OFS_REACH_FREQ, 32'h7530);
    $display("test reach done");
    wr(OFS_PROT_MASK, 32'h1F);
    drive(7'h22, 16'h03E8, 16'h0, 16'h02BC, 16'h0175);
    step(3);
    chk("decelHold", 32'h0, 32'(decelHold));
    chk("thermalTimerRun", 32'h1, 32'(thermalTimerRun));
    chk("avrEnable", 32'h1, 32'(avrEnable));
    drive(7'h22, 16'h03E8, 16'h0, 16'h02BC, 16'h0176);
    step(1);
    chk("decelHold", 32'h1, 32'(decelHold));
    wr(OFS_PROT_MASK, 32'h0);
    step(3);
    chk("decelHold", 32'h0, 32'(decelHold));
    chk("thermalTimerRun", 32'h0, 32'(thermalTimerRun));
    chk("avrEnable", 32'h0, 32'(avrEnable));
    wr(OFS_PROT_MASK, 32'h2);
    drive(7'h24, 16'h03E8, 16'h0, 16'h02A9);
    step(3);
    chk("accelHold", 32'h1, 32'(accelHold));
    drive(7'h24, 16'h03E8, 16'h0, 16'h02A8);
    step(1);
    chk("accelHold", 32'h0, 32'(accelHold));
    wr(OFS_PROT_MASK, 32'h4);
    drive(7'h20, 16'h03E8, 16'h0, 16'h0281);
    step(3);
    chk("runHold", 32'h1, 32'(runHold));
    rd(OFS_PROT_MASK, 32'h4);
    rd(OFS_STATUS, 32'h24);
    $display("test protection done");
    wr(OFS_SKIP_CENTER, 32'h1388);
    wr(OFS_SKIP_BAND, 32'h0064);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      targetFreq <= SKIP_T[i];
      step(1);
      chk("steadyTargetFreq", 32'(SKIP_E[i]), 32'(steadyTargetFreq));
    end
    wr(OFS_SKIP_BAND, 32'h0);
    @(posedge clk);
    targetFreq <= 16'h137E;
    step(3);
    chk("steadyTargetFreq", 32'h137E, 32'(steadyTargetFreq));
    wr(OFS_SKIP_BAND, 32'hFFFF);
    rd(OFS_SKIP_BAND, 32'h03E8);
    $display("test skip band done");
    close_out();
  end
endmodule
bind drive_status_output_logic drive_status_monitor mon_u (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
  .regRdata, .faultDetected, .driveActive, .forwardRunCommand, .outFreq, .rampDown, .dcBusVolt, .digitalOut,
  .decelHold, .thermalTimerRun, .avrEnable);
